/* rtl/spr_sdram_core.sv */
// Command engine: bursts, precharge, refresh, power-down and clock suspend
`timescale 1ns/10ps
`default_nettype none
`include "spr_cfg.svh"
module spr_sdram_core import spr_pkg::*; #(
  parameter int unsigned REF_INT_CYC = `SPR_REF_INT_CYC
) (
  input  wire logic        sys_clk_in,
  input  wire logic        arst_n_in,
  input  wire logic        cke_in,
  input  wire logic        cs_n_in,
  input  wire logic        ras_n_in,
  input  wire logic        cas_n_in,
  input  wire logic        we_n_in,
  input  wire logic [11:0] addr_in,
  input  wire logic        bank_select_low_in,
  input  wire logic        bank_select_high_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  output logic      [7:0]  col_addr_out,
  output logic      [1:0]  col_bank_out,
  output logic             col_rd_out,
  output logic             col_wr_out,
  output logic             rd_valid_out,
  output logic             refresh_out,
  output logic      [11:0] refresh_row_out,
  output logic      [3:0]  bank_open_out,
  output logic             power_down_out,
  output logic             self_refresh_out
);
  logic [1:0]  bsel;
  spr_cmd_type cmd;
  logic        cke_q, ien, acc, new_rd, new_wr, new_ref, new_bst, act_cmd, raw_nop;
  logic [9:0]  mode_q, mode_d;
  logic        wbs, page;
  logic [7:0]  len_m1;
  logic [3:0]  pre_cmd, pre_now, wrec_now, bank_open, prech, wrec_busy;
  logic        intr;
  assign bsel    = {bank_select_high_in, bank_select_low_in};
  assign cmd     = cs_n_in ? CMD_NOP : spr_cmd_type'({ras_n_in, cas_n_in, we_n_in});
  assign raw_nop = (cmd == CMD_NOP);
  spr_pw_type  pw_q, pw_d;
  // Suspended edge: gate sampled low on the previous edge
  assign ien     = cke_q;
  assign acc     = (pw_q == PW_RUN) && ien;
  assign new_rd  = acc && (cmd == CMD_RD);
  assign new_wr  = acc && (cmd == CMD_WR);
  assign new_bst = acc && (cmd == CMD_BST);
  assign act_cmd = acc && (cmd == CMD_ACT);
  assign new_ref = acc && (cmd == CMD_REF) && cke_in;
  assign pre_cmd = (acc && cmd == CMD_PRE) ?
                   (addr_in[`SPR_AP_BIT] ? 4'hf : (4'h1 << bsel)) : 4'h0;
  assign wbs     = mode_q[`SPR_WBS_BIT];
  assign page    = (mode_q[2:0] == `SPR_BL_PAGE);
  always_comb begin
    case (mode_q[2:0])
      3'h0:    len_m1 = 8'h00;
      3'h1:    len_m1 = 8'h01;
      3'h2:    len_m1 = 8'h03;
      3'h3:    len_m1 = 8'h07;
      default: len_m1 = 8'hff;
    endcase
  end
  // Burst engine
  logic       bst_act_q, bst_act_d, bst_wr_q, bst_wr_d, bst_ap_q, bst_ap_d;
  logic       bst_page_q, bst_page_d;
  logic [1:0] bst_bank_q, bst_bank_d, cbank_q, cbank_d;
  logic [7:0] bst_start_q, bst_start_d, bst_off_q, bst_off_d, bst_len_q, bst_len_d;
  logic [7:0] col_q, col_d, mix, col_calc, new_len;
  logic       crd_q, crd_d, cwr_q, cwr_d, new_ap, ap_end;
  assign mix      = mode_q[`SPR_ILV_BIT] ? (bst_start_q ^ bst_off_q)
                                           : 8'(bst_start_q + bst_off_q);
  assign col_calc = (bst_start_q & ~bst_len_q) | (mix & bst_len_q);
  assign new_len  = (new_wr && wbs && !page) ? 8'h00 : len_m1;
  assign new_ap   = addr_in[`SPR_AP_BIT] && !page;
  always_comb begin
    bst_act_d   = bst_act_q;
    bst_wr_d    = bst_wr_q;
    bst_ap_d    = bst_ap_q;
    bst_page_d  = bst_page_q;
    bst_bank_d  = bst_bank_q;
    bst_start_d = bst_start_q;
    bst_off_d   = bst_off_q;
    bst_len_d   = bst_len_q;
    col_d       = col_q;
    cbank_d     = cbank_q;
    crd_d       = 1'b0;
    cwr_d       = 1'b0;
    pre_now     = 4'h0;
    wrec_now    = 4'h0;
    intr        = 1'b0;
    ap_end      = 1'b0;
    if (new_rd || new_wr) begin
      if (bst_act_q && bst_ap_q && bst_bank_q != bsel) begin
        intr = 1'b1;
        if (bst_wr_q) wrec_now[bst_bank_q] = 1'b1;
        else          pre_now[bst_bank_q]  = 1'b1;
      end
      bst_len_d   = new_len;
      bst_page_d  = page;
      bst_ap_d    = new_ap;
      bst_start_d = addr_in[7:0];
      bst_off_d   = 8'h01;
      bst_bank_d  = bsel;
      bst_wr_d    = new_wr;
      bst_act_d   = (new_len != 8'h00);
      col_d       = addr_in[7:0];
      cbank_d     = bsel;
      crd_d       = new_rd;
      cwr_d       = new_wr;
      if (new_len == 8'h00 && new_ap) begin
        ap_end = 1'b1;
        if (new_wr) wrec_now[bsel] = 1'b1;
        else        pre_now[bsel]  = 1'b1;
      end
    end else if (new_bst) begin
      bst_act_d = 1'b0;
    end else if (ien && bst_act_q) begin
      // Held while suspended so no column is skipped
      col_d     = col_calc;
      cbank_d   = bst_bank_q;
      crd_d     = !bst_wr_q;
      cwr_d     = bst_wr_q;
      bst_off_d = 8'(bst_off_q + 8'h01);
      if (bst_off_q == bst_len_q && !bst_page_q) begin
        bst_act_d = 1'b0;
        if (bst_ap_q) begin
          ap_end = 1'b1;
          if (bst_wr_q) wrec_now[bst_bank_q] = 1'b1;
          else          pre_now[bst_bank_q]  = 1'b1;
        end
      end
    end
  end
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      bst_act_q   <= 1'b0;
      bst_wr_q    <= 1'b0;
      bst_ap_q    <= 1'b0;
      bst_page_q  <= 1'b0;
      bst_bank_q  <= 2'h0;
      bst_start_q <= 8'h00;
      bst_off_q   <= 8'h00;
      bst_len_q   <= 8'h00;
      col_q       <= 8'h00;
      cbank_q     <= 2'h0;
      crd_q       <= 1'b0;
      cwr_q       <= 1'b0;
    end else begin
      bst_act_q   <= bst_act_d;
      bst_wr_q    <= bst_wr_d;
      bst_ap_q    <= bst_ap_d;
      bst_page_q  <= bst_page_d;
      bst_bank_q  <= bst_bank_d;
      bst_start_q <= bst_start_d;
      bst_off_q   <= bst_off_d;
      bst_len_q   <= bst_len_d;
      col_q       <= col_d;
      cbank_q     <= cbank_d;
      crd_q       <= crd_d;
      cwr_q       <= cwr_d;
    end
  end
  // Read valid pipeline, frozen while suspended so output data stays put
  logic [2:0] rdp_q, rdp_d;
  always_comb begin
    rdp_d = ien ? {rdp_q[1:0], crd_d} : rdp_q;
  end
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) rdp_q <= 3'h0;
    else            rdp_q <= rdp_d;
  end
  always_comb begin
    case (mode_q[6:4])
      3'h2:    rd_valid_out = rdp_q[1];
      3'h3:    rd_valid_out = rdp_q[2];
      default: rd_valid_out = rdp_q[0];
    endcase
  end
  // Per-bank timers run on the bare clock: they measure real time
  for (genvar b = 0; b < 4; b++) begin : g_bank
    logic       open_q, open_d, start;
    logic [3:0] pc_q, pc_d, wc_q, wc_d;
    always_comb begin
      start  = pre_now[b] | pre_cmd[b] | (wc_q == 4'h1);
      open_d = open_q;
      pc_d   = (pc_q != 4'h0) ? 4'(pc_q - 4'h1) : pc_q;
      wc_d   = (wc_q != 4'h0) ? 4'(wc_q - 4'h1) : wc_q;
      if (act_cmd && bsel == 2'(b)) open_d = 1'b1;
      if (start) begin
        open_d = 1'b0;
        pc_d   = `SPR_ROW_CLOSE_CYC;
      end
      if (wrec_now[b]) wc_d = `SPR_WR_REC_CYC;
    end
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
        open_q <= 1'b0;
        pc_q   <= 4'h0;
        wc_q   <= 4'h0;
      end else begin
        open_q <= open_d;
        pc_q   <= pc_d;
        wc_q   <= wc_d;
      end
    end
    assign bank_open[b] = open_q;
    assign prech[b]     = (pc_q != 4'h0);
    assign wrec_busy[b] = (wc_q != 4'h0);
  end
  // Power modes and refresh row counter
  logic [4:0]  tmr_q, tmr_d;
  logic [12:0] tick_q, tick_d;
  logic [11:0] row_q, row_d;
  logic        ref_q, ref_d, idle_all;
  assign idle_all = (bank_open == 4'h0) && (prech == 4'h0) && (wrec_busy == 4'h0);
  always_comb begin
    pw_d   = pw_q;
    tmr_d  = (tmr_q != 5'h00) ? 5'(tmr_q - 5'h01) : tmr_q;
    tick_d = tick_q;
    row_d  = row_q;
    ref_d  = 1'b0;
    if (new_ref) begin
      ref_d = 1'b1;
      row_d = 12'(row_q + 12'h001);
    end
    case (pw_q)
      PW_RUN: begin
        if (cke_q && !cke_in && cmd == CMD_REF && idle_all && !bst_act_q) begin
          pw_d   = PW_SR;
          tmr_d  = `SPR_ROW_ACT_CYC;
          tick_d = 13'h0000;
        end else if (cke_q && !cke_in && raw_nop && !bst_act_q) begin
          pw_d = PW_PD;
        end
      end
      PW_PD: begin
        if (cke_in && raw_nop) pw_d = PW_RUN;
      end
      PW_SR: begin
        tick_d = 13'(tick_q + 13'h0001);
        if (tick_q == 13'(REF_INT_CYC - 1)) begin
          tick_d = 13'h0000;
          ref_d  = 1'b1;
          row_d  = 12'(row_q + 12'h001);
        end
        // Early exit attempts are held off until row active time is met
        if (cke_in && tmr_q == 5'h00) begin
          pw_d  = PW_XSR;
          tmr_d = `SPR_XSR_CYC;
        end
      end
      PW_XSR: begin
        if (tmr_q == 5'h00) pw_d = PW_RUN;
      end
      default: pw_d = PW_RUN;
    endcase
  end
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pw_q   <= PW_RUN;
      tmr_q  <= 5'h00;
      tick_q <= 13'h0000;
      row_q  <= 12'h000;
      ref_q  <= 1'b0;
      cke_q  <= 1'b1;
    end else begin
      pw_q   <= pw_d;
      tmr_q  <= tmr_d;
      tick_q <= tick_d;
      row_q  <= row_d;
      ref_q  <= ref_d;
      cke_q  <= cke_in;
    end
  end
  // AHB-Lite slave, zero wait states
  logic        go, wpend_q, wpend_d;
  logic [7:0]  waddr_q, waddr_d;
  logic [31:0] rdat_q, rdat_d;
  assign go = hsel_in && hready_in && htrans_in[1];
  always_comb begin
    wpend_d = go && hwrite_in;
    waddr_d = go ? haddr_in[7:0] : waddr_q;
    mode_d  = mode_q;
    rdat_d  = 32'h0000_0000;
    if (wpend_q && waddr_q == `SPR_MODE_OFS) mode_d = hwdata_in[9:0] & `SPR_MODE_MASK;
    if (go && !hwrite_in) begin
      case (haddr_in[7:0])
        `SPR_MODE_OFS: rdat_d = {22'h000000, mode_q};
        `SPR_STAT_OFS: rdat_d = {21'h000000, bst_act_q, pw_q == PW_SR, pw_q == PW_PD,
                                 prech, bank_open};
        `SPR_ROW_OFS:  rdat_d = {20'h00000, row_q};
        default:       rdat_d = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wpend_q <= 1'b0;
      waddr_q <= 8'h00;
      rdat_q  <= 32'h0000_0000;
      mode_q  <= `SPR_MODE_RST;
    end else begin
      wpend_q <= wpend_d;
      waddr_q <= waddr_d;
      rdat_q  <= rdat_d;
      mode_q  <= mode_d;
    end
  end
  assign hrdata_out       = rdat_q;
  assign hreadyout_out    = 1'b1;
  assign hresp_out        = 1'b0;
  assign col_addr_out     = col_q;
  assign col_bank_out     = cbank_q;
  assign col_rd_out       = crd_q;
  assign col_wr_out       = cwr_q;
  assign refresh_out      = ref_q;
  assign refresh_row_out  = row_q;
  assign bank_open_out    = bank_open;
  assign power_down_out   = (pw_q == PW_PD);
  assign self_refresh_out = (pw_q == PW_SR);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);
  wbs_single_a: assert property (new_wr && wbs && !page |=> !bst_act_q && cwr_q)
    else $error("single-location write ran a burst");
  rd_burst_a: assert property (new_rd && wbs && len_m1 != 8'h00 |=> bst_act_q && !bst_wr_q)
    else $error("read burst not started");
  pre_all_a: assert property (acc && cmd == CMD_PRE && addr_in[`SPR_AP_BIT] |=> prech == 4'hf)
    else $error("precharge all missed a bank");
  // Only the burst-end case: a single-beat access closes the newly addressed bank instead
  auto_pre_a: assert property (ap_end && !bst_wr_q && !new_rd && !new_wr
                               |=> prech[$past(bst_bank_q)])
    else $error("auto precharge not started");
  page_noap_a: assert property (bst_act_q && bst_page_q |-> !bst_ap_q)
    else $error("auto precharge on page burst");
  rd_cut_a: assert property (intr && !bst_wr_q |=> prech[$past(bst_bank_q)])
    else $error("interrupted read not precharging");
  // Recovery is three cycles at this clock; the burst bank has moved on by then
  wr_cut_a: assert property (intr && bst_wr_q |=> wrec_busy[$past(bst_bank_q)]
                             ##3 prech[$past(bst_bank_q, 4)])
    else $error("interrupted write recovery wrong");
  ref_row_a: assert property (new_ref |=> refresh_out && refresh_row_out == $past(row_q) + 12'h001)
    else $error("refresh row not from counter");
  sr_hold_a: assert property (pw_q == PW_SR && tmr_q != 5'h00 |=> pw_q == PW_SR)
    else $error("self refresh left too early");
  pd_entry_a: assert property (pw_q == PW_RUN && cke_q && !cke_in && raw_nop && !bst_act_q
                               |=> power_down_out)
    else $error("power-down not entered");
  suspend_a: assert property (!cke_q && bst_act_q && pw_q == PW_RUN |=> $stable(bst_off_q))
    else $error("burst advanced while suspended");
  cut_c: cover property (intr);
  sr_c: cover property (pw_q == PW_SR ##1 pw_q == PW_XSR);
  pd_c: cover property (power_down_out ##1 !power_down_out);
  susp_c: cover property (bst_act_q && !cke_q);
endmodule
`default_nettype wire

/* rtl/spr_cfg.svh */
// Constants for the SDRAM precharge, refresh and power-mode engine
`ifndef SPR_CFG_SVH
`define SPR_CFG_SVH
`define SPR_CLK_NS       5
`define SPR_CYC(ns)      (((ns) + `SPR_CLK_NS - 1) / `SPR_CLK_NS)
`define SPR_ROW_CLOSE_NS 18
`define SPR_WR_REC_NS    12
`define SPR_ROW_ACT_NS   42
`define SPR_XSR_NS       70
`define SPR_REF_INT_NS   15625
`define SPR_ROW_CLOSE_CYC 4'(`SPR_CYC(`SPR_ROW_CLOSE_NS))
`define SPR_WR_REC_CYC    4'(`SPR_CYC(`SPR_WR_REC_NS))
`define SPR_ROW_ACT_CYC   5'(`SPR_CYC(`SPR_ROW_ACT_NS))
`define SPR_XSR_CYC       5'(`SPR_CYC(`SPR_XSR_NS))
`define SPR_REF_INT_CYC   `SPR_CYC(`SPR_REF_INT_NS)
`define SPR_MODE_OFS  8'h00
`define SPR_STAT_OFS  8'h04
`define SPR_ROW_OFS   8'h08
`define SPR_MODE_RST  10'h020
`define SPR_MODE_MASK 10'h27f
`define SPR_WBS_BIT   9
`define SPR_ILV_BIT   3
`define SPR_BL_PAGE   3'h7
`define SPR_AP_BIT    10
`endif

/* rtl/spr_pkg.sv */
// Types for the SDRAM precharge, refresh and power-mode engine
package spr_pkg;
  typedef enum logic [2:0] {
    CMD_MRS = 3'b000, CMD_REF = 3'b001, CMD_PRE = 3'b010, CMD_ACT = 3'b011,
    CMD_WR  = 3'b100, CMD_RD  = 3'b101, CMD_BST = 3'b110, CMD_NOP = 3'b111
  } spr_cmd_type;
  typedef enum logic [1:0] {
    PW_RUN = 2'b00, PW_PD = 2'b01, PW_SR = 2'b10, PW_XSR = 2'b11
  } spr_pw_type;
endpackage

/* test/spr_ctl_model.sv */
// Memory controller model that drives the command pins
`timescale 1ns/10ps
`default_nettype none
module spr_ctl_model import spr_pkg::*; #(
  parameter int ROW_CLOSE = 4,
  parameter int RFC_CYC   = 14,
  parameter int AP_WAIT   = 20
) (
  input  wire logic        sys_clk_in,
  output logic             cke_out,
  output logic             cs_n_out,
  output logic             ras_n_out,
  output logic             cas_n_out,
  output logic             we_n_out,
  output logic      [11:0] addr_out,
  output logic             bank_low_out,
  output logic             bank_high_out
);
  int unsigned cyc = 0;
  int unsigned ready_at [4] = '{default: 0};
  initial begin
    cke_out = 1'b1;
    cs_n_out = 1'b0;
    {ras_n_out, cas_n_out, we_n_out} = 3'b111;
    addr_out = 12'h000;
    {bank_high_out, bank_low_out} = 2'h0;
  end
  always @(posedge sys_clk_in) cyc <= cyc + 1;
  // Per-bank cycle timers; a bank is left alone until its wait runs out
  task automatic send(input spr_cmd_type c, input logic [11:0] a, input logic [1:0] b,
                      input logic k);
    int n;
    n = 0;
    while (cyc < ready_at[b] && n < 64) begin
      @(posedge sys_clk_in);
      n++;
    end
    if (n >= 64) begin
      tb.chk(1'b0, "controller wait limit");
      tb.conclude();
    end
    @(posedge sys_clk_in);
    cke_out <= k;
    {ras_n_out, cas_n_out, we_n_out} <= c;
    addr_out <= a;
    {bank_high_out, bank_low_out} <= b;
    for (int i = 0; i < 4; i++) begin
      if (c == CMD_REF || (c == CMD_PRE && (a[10] || i == b)))
        ready_at[i] = cyc + (c == CMD_REF ? RFC_CYC : ROW_CLOSE) + 1;
    end
    if ((c == CMD_RD || c == CMD_WR) && a[10])
      ready_at[b] = cyc + AP_WAIT;
    @(posedge sys_clk_in);
    {ras_n_out, cas_n_out, we_n_out} <= 3'b111;
    // Address is a don't-care after the command, so it does not hold
    addr_out <= ~a;
  endtask
endmodule
`default_nettype wire

/* test/tb.sv */
// Self-checking bench for the SDRAM command engine
`timescale 1ns/10ps
`default_nettype none
module tb import spr_pkg::*;;
  logic        sys_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] seed = 32'hb2aad026;
  logic [31:0] rd;
  wire logic   cke, cs_n, ras_n, cas_n, we_n, bsl, bsh, hreadyout, hresp;
  wire logic   col_rd, col_wr, rd_valid, refresh, power_down, self_refresh;
  wire logic [31:0] hrdata;
  wire logic [11:0] addr, refresh_row;
  wire logic [7:0]  col_addr;
  wire logic [1:0]  col_bank;
  wire logic [3:0]  bank_open;
  int          num_errors = 0, checks_done = 0, cyc = 0, n_rv = 0, n_rf = 0;
  logic [8:0]  cols [$];
  int          stamps [$];
  always #2.5 sys_clk = ~sys_clk;
  spr_ctl_model ctl (.sys_clk_in(sys_clk), .cke_out(cke), .cs_n_out(cs_n), .ras_n_out(ras_n),
    .cas_n_out(cas_n), .we_n_out(we_n), .addr_out(addr), .bank_low_out(bsl),
    .bank_high_out(bsh));
  spr_sdram_core #(.REF_INT_CYC(8)) dut (.sys_clk_in(sys_clk), .arst_n_in(arst_n),
    .cke_in(cke), .cs_n_in(cs_n), .ras_n_in(ras_n), .cas_n_in(cas_n), .we_n_in(we_n),
    .addr_in(addr), .bank_select_low_in(bsl), .bank_select_high_in(bsh), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
    .hwdata_in(hwdata), .hready_in(hreadyout), .hrdata_out(hrdata),
    .hreadyout_out(hreadyout), .hresp_out(hresp), .col_addr_out(col_addr),
    .col_bank_out(col_bank), .col_rd_out(col_rd), .col_wr_out(col_wr),
    .rd_valid_out(rd_valid), .refresh_out(refresh), .refresh_row_out(refresh_row),
    .bank_open_out(bank_open), .power_down_out(power_down), .self_refresh_out(self_refresh));
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (col_rd === 1'b1 || col_wr === 1'b1) begin
      cols.push_back({col_wr, col_addr});
      stamps.push_back(cyc);
    end
    if (rd_valid === 1'b1) n_rv <= n_rv + 1;
    if (refresh === 1'b1) n_rf <= n_rf + 1;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [7:0] ecol(input logic [7:0] s, input int len, input logic il,
                                      input int k);
    logic [7:0] m;
    m = 8'(len - 1);
    return (s & ~m) | ((il ? (s ^ 8'(k)) : (s + 8'(k))) & m);
  endfunction
  task automatic conclude();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("MISMATCH at %0t: %s", $time, m);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    rd = hrdata;
    chk(hresp === 1'b0, "bus response");
    if (n >= 40) begin
      chk(1'b0, "bus wait limit");
      conclude();
    end
  endtask
  task automatic setm(input logic [2:0] bl, input logic il, input logic [2:0] cl, input logic ws);
    ahb(1'b1, 32'h0, {22'h0, ws, 2'b00, cl, il, bl});
  endtask
  // Runs one access and compares the column stream against the expected order
  task automatic burst(input spr_cmd_type c, input logic [7:0] s, input logic [1:0] b,
                       input logic ap, input int len, input logic il);
    int v;
    cols.delete();
    v = n_rv;
    ctl.send(c, {1'b0, ap, 2'b00, s}, b, 1'b1);
    wt(len + 6);
    chk(cols.size() == len, "burst length");
    chk(col_bank === b, "column bank");
    foreach (cols[k]) chk(cols[k] === {c == CMD_WR, ecol(s, len, il, k)}, "column order");
    if (c == CMD_RD) chk(n_rv - v == len, "read valid count");
  endtask
  initial begin
    logic [31:0] r;
    logic [11:0] r0;
    logic [1:0]  b;
    int          v;
    repeat (5) @(posedge sys_clk);
    arst_n <= 1'b1;
    chk(bank_open === 4'h0 && refresh_row === 12'h0 && power_down === 1'b0, "reset outputs");
    ahb(1'b0, 32'h0, 32'h0);
    chk(rd === 32'h20, "mode reset value");
    ahb(1'b1, 32'h0, 32'hffffffff);
    ahb(1'b0, 32'h0, 32'h0);
    chk(rd === 32'h27f, "mode writable bits");
    ahb(1'b1, 32'h4, 32'hffffffff);
    ahb(1'b0, 32'h4, 32'h0);
    chk(rd === 32'h0, "status read only");
    ahb(1'b0, 32'h10, 32'h0);
    chk(rd === 32'h0, "unmapped read");
    for (int i = 0; i < 6; i++) begin
      r = rnd();
      b = r[17:16];
      setm(3'(i % 4), r[2], 3'(1 + r[5:4] % 3), i[0]);
      ctl.send(CMD_ACT, r[27:16], b, 1'b1);
      burst(CMD_RD, r[15:8], b, 1'b0, 1 << (i % 4), r[2]);
      burst(CMD_WR, r[15:8], b, 1'b0, i[0] ? 1 : 1 << (i % 4), r[2]);
      ctl.send(CMD_PRE, 12'h000, b, 1'b1);
    end
    for (int k = 0; k < 4; k++) ctl.send(CMD_ACT, 12'(rnd()), 2'(k), 1'b1);
    b = 2'(rnd());
    ctl.send(CMD_PRE, 12'h000, b, 1'b1);
    wt(2);
    chk(bank_open === ~(4'h1 << b), "single bank precharge");
    ctl.send(CMD_PRE, 12'h400, 2'(rnd()), 1'b1);
    wt(2);
    chk(bank_open === 4'h0, "all bank precharge");
    setm(3'h2, 1'b0, 3'h2, 1'b0);
    ctl.send(CMD_ACT, 12'h0, 2'h1, 1'b1);
    burst(CMD_RD, 8'h13, 2'h1, 1'b1, 4, 1'b0);
    chk(bank_open[1] === 1'b0, "auto precharge closes bank");
    ctl.send(CMD_ACT, 12'h0, 2'h1, 1'b1);
    burst(CMD_RD, 8'h13, 2'h1, 1'b0, 4, 1'b0);
    chk(bank_open[1] === 1'b1, "bank stays open without selector");
    setm(3'h7, 1'b0, 3'h2, 1'b1);
    ctl.send(CMD_WR, 12'h455, 2'h1, 1'b1);
    wt(12);
    chk(bank_open[1] === 1'b1, "page burst keeps bank open");
    ctl.send(CMD_BST, 12'h0, 2'h1, 1'b1);
    ctl.send(CMD_PRE, 12'h400, 2'h1, 1'b1);
    setm(3'h3, 1'b0, 3'h2, 1'b0);
    // Second access lands mid-burst; read banks close at once, write banks recover first
    for (int k = 0; k < 4; k++) begin
      ctl.send(CMD_ACT, 12'h0, 2'h0, 1'b1);
      ctl.send(CMD_ACT, 12'h0, 2'h1, 1'b1);
      ctl.send(k[1] ? CMD_WR : CMD_RD, 12'h400, 2'h0, 1'b1);
      ctl.send(k[0] ? CMD_WR : CMD_RD, 12'h000, 2'h1, 1'b1);
      wt(2);
      chk(bank_open === (k[1] ? 4'h3 : 4'h2), "interrupted bank early");
      wt(6);
      chk(bank_open === 4'h2, "interrupted bank closed");
      ctl.send(CMD_PRE, 12'h400, 2'h0, 1'b1);
    end
    for (int k = 0; k < 2; k++) begin
      r0 = refresh_row;
      v = n_rf;
      ctl.send(CMD_REF, 12'(rnd()), 2'(rnd()), 1'b1);
      wt(3);
      chk(n_rf - v == 1 && refresh_row === r0 + 12'h1, "auto refresh row");
    end
    v = n_rf;
    ctl.send(CMD_REF, 12'h0, 2'h0, 1'b0);
    wt(2);
    chk(self_refresh === 1'b1, "self refresh entry");
    ctl.send(CMD_ACT, 12'h0, 2'h2, 1'b0);
    wt(30);
    chk(bank_open === 4'h0 && n_rf - v >= 4, "self refresh runs alone");
    ctl.send(CMD_NOP, 12'h0, 2'h0, 1'b1);
    wt(20);
    chk(self_refresh === 1'b0, "self refresh exit");
    r0 = refresh_row;
    ctl.send(CMD_REF, 12'h0, 2'h2, 1'b1);
    wt(2);
    chk(refresh_row === r0 + 12'h1, "refresh resumes after exit");
    ctl.send(CMD_ACT, 12'h0, 2'h2, 1'b1);
    wt(2);
    chk(bank_open === 4'h4, "commands after exit");
    ctl.send(CMD_NOP, 12'h0, 2'h0, 1'b0);
    wt(1);
    chk(power_down === 1'b1, "active power-down entry");
    ctl.send(CMD_PRE, 12'h400, 2'h2, 1'b0);
    wt(2);
    chk(bank_open === 4'h4 && power_down === 1'b1, "power-down ignores commands");
    ctl.send(CMD_NOP, 12'h0, 2'h0, 1'b1);
    wt(2);
    chk(power_down === 1'b0, "power-down exit");
    cols.delete();
    stamps.delete();
    ctl.send(CMD_RD, 12'h0, 2'h2, 1'b1);
    ctl.send(CMD_NOP, 12'h0, 2'h2, 1'b0);
    ctl.send(CMD_NOP, 12'h0, 2'h2, 1'b1);
    wt(14);
    chk(cols.size() == 8 && stamps[7] - stamps[0] == 9, "suspend stretches burst");
    conclude();
  end
endmodule
`default_nettype wire
